/* dv/lfs_mcu_model.sv */
// Microcontroller model issuing register reads and writes
`timescale 1ns/100ps
module lfs_mcu_model (
  // Clock
  input  wire logic        core_clk_in,
  // Register access
  output logic      [4:0]  reg_addr_out,
  output logic             reg_wr_out,
  output logic             reg_rd_out,
  output logic      [12:0] reg_wdata_out,
  input  wire logic [12:0] reg_rdata_in,
  input  wire logic        reg_rvalid_in
);
  // Idle access port at time zero
  initial begin
    reg_addr_out  = 5'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_wdata_out = 13'h0000;
  end
  // Write strobe for one taking edge
  task automatic wr(input logic [4:0] a, input logic [12:0] d);
    @(posedge core_clk_in);
    reg_addr_out  <= a;
    reg_wdata_out <= d;
    reg_wr_out    <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_out    <= 1'b0;
    reg_wdata_out <= ~d; // Released data never keeps the old word
  endtask
  // Read strobe, answer one cycle after the taking edge
  task automatic rd(input logic [4:0] a, output logic [12:0] d, output logic ok);
    @(posedge core_clk_in);
    reg_addr_out <= a;
    reg_rd_out   <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_out <= 1'b0;
    // Answer taken at the edge where the valid pulse is sampled high
    @(posedge core_clk_in);
    d  = reg_rdata_in;
    ok = reg_rvalid_in;
  endtask
endmodule

/* dv/lfs_status_chk.sv */
// Port-level assertions for the LED status register bank
`timescale 1ns/100ps
module lfs_status_chk (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Register read side
  input  wire logic        reg_rd_in,
  input  wire logic [12:0] reg_rdata_out,
  input  wire logic        reg_rvalid_out,
  // Switches and group writes
  input  wire logic [11:0] normal_sw_closed_in,
  input  wire logic [11:0] switch_closed_out,
  input  wire logic        group_phase_write_in,
  input  wire logic [3:0]  phase_group_select_in,
  input  wire logic [47:0] drv_phase_out,
  input  wire logic        transition_write_in,
  input  wire logic [3:0]  transition_group_select_in,
  input  wire logic [47:0] drv_transition_out,
  // Summaries and alert
  input  wire logic        any_open_summary_out,
  input  wire logic        any_trace_summary_out,
  input  wire logic        any_short_summary_out,
  input  wire logic        fault_alert_pin_n_out
);
  // ********************************
  // Checks
  // ********************************
  default clocking dc @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // Answer one cycle after the strobe
  sequence s_read_answer;
    ##1 reg_rvalid_out && !reg_rdata_out[12];
  endsequence
  a_read_answer: assert property (reg_rd_in |-> s_read_answer)
    else $error("read answer missing");
  a_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("read answer without strobe");
  a_alert_follows: assert property (fault_alert_pin_n_out !=
    $past(any_open_summary_out || any_trace_summary_out || any_short_summary_out))
    else $error("alert pin does not follow summaries");
  a_normal_closes: assert property (
    (switch_closed_out & $past(normal_sw_closed_in)) == $past(normal_sw_closed_in))
    else $error("normal close request lost");
  a_phase_zero_sel: assert property (group_phase_write_in &&
    phase_group_select_in == 4'h0 |=> $stable(drv_phase_out))
    else $error("phase changed by empty select");
  a_transition_dimming_setting_zero_sel: assert property (transition_write_in &&
    transition_group_select_in == 4'h0 |=> $stable(drv_transition_out))
    else $error("transition changed by empty select");
  a_phase_cause: assert property (!group_phase_write_in |=> $stable(drv_phase_out))
    else $error("phase changed without write");
  a_transition_dimming_setting_cause: assert property (!transition_write_in |=> $stable(drv_transition_out))
    else $error("transition changed without write");
endmodule
bind lfs_status_regs lfs_status_chk lfs_status_chk_i (
  .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .normal_sw_closed_in(normal_sw_closed_in), .switch_closed_out(switch_closed_out),
  .group_phase_write_in(group_phase_write_in), .phase_group_select_in(phase_group_select_in),
  .drv_phase_out(drv_phase_out), .transition_write_in(transition_write_in),
  .transition_group_select_in(transition_group_select_in),
  .drv_transition_out(drv_transition_out), .any_open_summary_out(any_open_summary_out),
  .any_trace_summary_out(any_trace_summary_out),
  .any_short_summary_out(any_short_summary_out),
  .fault_alert_pin_n_out(fault_alert_pin_n_out));

/* dv/tb_top.sv */
// Self-checking testbench for the LED status register bank
`timescale 1ns/100ps
module tb_top;
  logic         core_clk = 1'b0;
  logic         rst = 1'b1;
  logic [4:0]   addr;
  logic         wr, rd, rvalid;
  logic [12:0]  wdata, rdata;
  logic [11:0]  det_open = 12'h000, det_trace = 12'h000, det_short = 12'h000;
  logic [11:0]  norm = 12'h000, duty = 12'h000, closed;
  logic         ph_wr = 1'b0, td_wr = 1'b0, da_wr = 1'b0, db_wr = 1'b0;
  logic [3:0]   ph_sel = 4'h0, ph_val = 4'h0, td_sel = 4'h0, td_val = 4'h0;
  logic [47:0]  ph_o, td_o, ph_e = '0, td_e = '0;
  logic [143:0] du_o, du_e = '0;
  logic         s_open, s_trace, s_short, alert_n;
  logic [11:0]  ma = 12'h000, mb = 12'h000, frc = 12'h000;
  int           fails = 0, cmp_count = 0;
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  lfs_mcu_model lfs_mcu_model_i (.core_clk_in(core_clk), .reg_addr_out(addr),
    .reg_wr_out(wr), .reg_rd_out(rd), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
    .reg_rvalid_in(rvalid));
  lfs_status_regs lfs_status_regs_i (.core_clk_in(core_clk), .rst_in(rst),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .any_open_summary_det_in(det_open),
    .open_trace_det_in(det_trace), .short_led_det_in(det_short), .normal_sw_closed_in(norm),
    .group_phase_write_in(ph_wr), .phase_group_select_in(ph_sel), .phase_value_in(ph_val),
    .transition_write_in(td_wr), .transition_group_select_in(td_sel),
    .transition_dimming_setting_in(td_val), .first_group_duty_wr_in(da_wr),
    .second_group_duty_wr_in(db_wr), .group_duty_in(duty), .switch_closed_out(closed),
    .drv_phase_out(ph_o), .drv_transition_out(td_o), .drv_eff_duty_out(du_o),
    .any_open_summary_out(s_open), .any_trace_summary_out(s_trace),
    .any_short_summary_out(s_short), .fault_alert_pin_n_out(alert_n));
  // ********************************
  // Compare and access tasks
  // ********************************
  task automatic chk_reg(input logic [12:0] g, input logic [12:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic chk_out(input logic [143:0] g, input logic [143:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t %s got %h expected %h", $time, m, g, e);
    end
  endtask
  task automatic rreg(input logic [4:0] a, input logic [12:0] e);
    logic [12:0] d;
    logic        ok;
    lfs_mcu_model_i.rd(a, d, ok);
    chk_reg(d, e, "read data");
    chk_reg({12'h000, ok}, 13'h0001, "read valid");
  endtask
  // Settings outputs against the group model, with forced drivers at zero duty
  task automatic chk_now();
    logic [143:0] e;
    #1;
    e = du_e;
    for (int i = 0; i < 12; i++) if (frc[i]) e[12*i+:12] = 12'h000;
    chk_out(ph_o, ph_e, "phase");
    chk_out(td_o, td_e, "transition");
    chk_out(du_o, e, "duty");
  endtask
  // Group write pulse: kind 0 phase, 1 transition, 2 duty A, 3 duty B
  task automatic grp(input int k, input logic [3:0] sel, input logic [11:0] v);
    logic hit;
    @(posedge core_clk);
    {ph_sel, td_sel, ph_val, td_val, duty} <= {sel, sel, v[3:0], v[3:0], v};
    {ph_wr, td_wr, da_wr, db_wr} <= {k == 0, k == 1, k == 2, k == 3};
    @(posedge core_clk);
    {ph_wr, td_wr, da_wr, db_wr} <= 4'h0;
    for (int i = 0; i < 12; i++) begin
      hit = (k < 2) ? ((sel[0] & ma[i]) | (sel[1] & mb[i])) : ((k == 2) ? ma[i] : mb[i]);
      if (hit && k == 0) ph_e[4*i+:4] = v[3:0];
      if (hit && k == 1) td_e[4*i+:4] = v[3:0];
      if (hit && k > 1) du_e[12*i+:12] = v;
    end
    chk_now();
  endtask
  task automatic results();
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    results();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (int a = 6; a < 12; a++) rreg(5'(a), 13'h0000);
    lfs_mcu_model_i.wr(5'h1f, 13'h1fff);
    rreg(5'h1f, 13'h0000);
    lfs_mcu_model_i.wr(lfs_pkg::OFS_ANY_OPEN_SUMMARY_STATUS, 13'h0fff);
    rreg(lfs_pkg::OFS_ANY_OPEN_SUMMARY_STATUS, 13'h0000);
    lfs_mcu_model_i.wr(lfs_pkg::OFS_GROUP_A_MEMBERS, 13'h10a5);
    ma = 12'h0a5;
    rreg(lfs_pkg::OFS_GROUP_A_MEMBERS, 13'h00a5);
    lfs_mcu_model_i.wr(lfs_pkg::OFS_GROUP_B_MEMBERS, 13'h05a0);
    mb = 12'h5a0;
    rreg(lfs_pkg::OFS_GROUP_B_MEMBERS, 13'h05a0);
    // Override one switch, request another closed normally
    norm <= 12'h100;
    lfs_mcu_model_i.wr(lfs_pkg::OFS_SWITCH_FORCE_CLOSED, 13'h0001);
    frc = 12'h001;
    @(posedge core_clk);
    #1;
    chk_out(closed, 12'h101, "switch state");
    rreg(lfs_pkg::OFS_SWITCH_FORCE_CLOSED, 13'h0001);
    // Faults on open and closed switches
    {det_open, det_trace, det_short} <= {12'h103, 12'h0c0, 12'h900};
    repeat (6) @(posedge core_clk);
    {det_open, det_trace, det_short} <= 36'h0;
    repeat (4) @(posedge core_clk);
    #1;
    chk_out({s_open, s_trace, s_short, alert_n}, 4'he, "summaries set");
    rreg(lfs_pkg::OFS_ANY_OPEN_SUMMARY_STATUS, 13'h0002);
    rreg(lfs_pkg::OFS_OPEN_TRACE_STATUS, 13'h00c0);
    rreg(lfs_pkg::OFS_SHORT_LED_STATUS, 13'h0800);
    #1;
    chk_out({s_open, s_trace, s_short, alert_n}, 4'h1, "summaries clear");
    rreg(lfs_pkg::OFS_ANY_OPEN_SUMMARY_STATUS, 13'h0000);
    rreg(lfs_pkg::OFS_SHORT_LED_STATUS, 13'h0000);
    // Group writes
    grp(0, 4'h1, 12'h005);
    grp(0, 4'h2, 12'h009);
    grp(0, 4'h0, 12'h00f);
    grp(0, 4'h3, 12'h003);
    grp(1, 4'h1, 12'h007);
    grp(1, 4'h0, 12'h00e);
    grp(1, 4'h2, 12'h00c);
    grp(2, 4'h0, 12'h123);
    grp(3, 4'h0, 12'h456);
    lfs_mcu_model_i.wr(lfs_pkg::OFS_SWITCH_FORCE_CLOSED, 13'h0000);
    frc = 12'h000;
    chk_now();
    results();
  end
endmodule

/* verilog/lfs_flag_bank.sv */
// Sticky per-driver fault flags with pin synchroniser and clear on read
`timescale 1ns/100ps
module lfs_flag_bank #(
  parameter int unsigned N = 12
) (
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  // Detection and control
  input  wire logic [N-1:0] det_in,
  input  wire logic [N-1:0] switch_open_in,
  input  wire logic         clear_in,
  // Flag state
  output logic      [N-1:0] flags_out,
  output logic              any_out
);
  logic [N-1:0] sync1_r;
  logic [N-1:0] sync2_r;
  logic [N-1:0] sync3_r;
  logic [N-1:0] flags_r;
  logic [N-1:0] flags_nxt;
  logic [N-1:0] seen;

  // Three stage synchroniser on the analog detector levels
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      sync1_r <= det_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Detection counts when stages two and three are both high, switch open only
  assign seen      = sync2_r & sync3_r & switch_open_in;
  // Set wins over the read clear
  assign flags_nxt = (clear_in ? '0 : flags_r) | seen;

  // Flag storage
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_out = flags_r;
  assign any_out   = |flags_r;
endmodule

/* verilog/lfs_group_lane.sv */
// One driver's group-written phase, transition and duty settings
`timescale 1ns/100ps
module lfs_group_lane (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Membership and override
  input  wire logic        member_a_in,
  input  wire logic        member_b_in,
  input  wire logic        force_in,
  // Group phase write
  input  wire logic        phase_wr_in,
  input  wire logic [3:0]  phase_sel_in,
  input  wire logic [3:0]  phase_val_in,
  // Group transition write
  input  wire logic        transition_dimming_setting_wr_in,
  input  wire logic [3:0]  transition_dimming_setting_sel_in,
  input  wire logic [3:0]  transition_dimming_setting_val_in,
  // Group duty writes
  input  wire logic        duty_a_wr_in,
  input  wire logic        duty_b_wr_in,
  input  wire logic [11:0] duty_val_in,
  // Driver settings
  output logic      [3:0]  phase_out,
  output logic      [3:0]  transition_dimming_setting_out,
  output logic      [11:0] eff_duty_out
);
  logic [3:0]  phase_r;
  logic [3:0]  transition_dimming_setting_r;
  logic [11:0] duty_r;
  wire         phase_hit;
  wire         transition_dimming_setting_hit;
  wire         duty_hit;

  // Qualified group hits; an all-zero select hits nothing
  assign phase_hit = phase_wr_in &
                     ((phase_sel_in[lfs_pkg::GSEL_BIT_A] & member_a_in) |
                      (phase_sel_in[lfs_pkg::GSEL_BIT_B] & member_b_in));
  assign transition_dimming_setting_hit  = transition_dimming_setting_wr_in &
                     ((transition_dimming_setting_sel_in[lfs_pkg::GSEL_BIT_A] & member_a_in) |
                      (transition_dimming_setting_sel_in[lfs_pkg::GSEL_BIT_B] & member_b_in));
  assign duty_hit  = (duty_a_wr_in & member_a_in) |
                     (duty_b_wr_in & member_b_in);

  // Setting storage
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      phase_r <= lfs_pkg::RST_PHASE;
      transition_dimming_setting_r  <= lfs_pkg::RST_TRANSITION_DIMMING_SETTING;
      duty_r  <= lfs_pkg::RST_DUTY;
    end else begin
      if (phase_hit) phase_r <= phase_val_in;
      if (transition_dimming_setting_hit) transition_dimming_setting_r <= transition_dimming_setting_val_in;
      if (duty_hit) duty_r <= duty_val_in;
    end
  end

  assign phase_out    = phase_r;
  assign transition_dimming_setting_out     = transition_dimming_setting_r;
  // Forced switch means zero effective duty
  assign eff_duty_out = force_in ? '0 : duty_r;
endmodule

/* verilog/lfs_pkg.sv */
// Package of offsets, widths, reset values and group codes for the LED status registers
package lfs_pkg;
  // ********************************
  // Sizes
  // ********************************
  localparam int unsigned DRIVERS   = 12;
  localparam int unsigned ADDR_W    = 5;
  localparam int unsigned DATA_W    = 13;
  localparam int unsigned PHASE_W   = 4;
  localparam int unsigned TRANSITION_DIMMING_SETTING_W    = 4;
  localparam int unsigned DUTY_W    = 12;
  localparam int unsigned GSEL_W    = 4;
  // ********************************
  // Register offsets
  // ********************************
  localparam logic [4:0] OFS_ANY_OPEN_SUMMARY_STATUS     = 5'h06;
  localparam logic [4:0] OFS_OPEN_TRACE_STATUS   = 5'h07;
  localparam logic [4:0] OFS_SWITCH_FORCE_CLOSED = 5'h08;
  localparam logic [4:0] OFS_SHORT_LED_STATUS    = 5'h09;
  localparam logic [4:0] OFS_GROUP_A_MEMBERS     = 5'h0a;
  localparam logic [4:0] OFS_GROUP_B_MEMBERS     = 5'h0b;
  // ********************************
  // Field layout and reset values
  // ********************************
  localparam int unsigned FLD_DRV_LSB = 0;
  localparam int unsigned FLD_DRV_MSB = 11;
  localparam logic [11:0] RST_FLAGS   = 12'h000;
  localparam logic [11:0] RST_FORCE   = 12'h000;
  localparam logic [11:0] RST_GROUP   = 12'h000;
  localparam logic [3:0]  RST_PHASE   = 4'h0;
  localparam logic [3:0]  RST_TRANSITION_DIMMING_SETTING    = 4'h0;
  localparam logic [11:0] RST_DUTY    = 12'h000;
  // ********************************
  // Group select bit positions
  // ********************************
  localparam int unsigned GSEL_BIT_A = 0;
  localparam int unsigned GSEL_BIT_B = 1;
endpackage

/* verilog/lfs_status_regs.sv */
// LED fault status, switch override and group membership register bank
`timescale 1ns/100ps

// Function
// - Any_open_summary flags per driver, clear on read
// - Open-trace flags per driver, clear on read
// - Shorted-LED flags per driver, clear on read
// - Override bit one holds switch closed
// - Overridden driver has zero effective duty
// - Clear override leaves normal switch control
// - Faults evaluated only while switch open
// - Group writes reach every member driver
// - Group A mask, select 0001, A duty
// - Group B mask, select 0010, B duty
// - All-zero group select ignores the write
// - Summary bits OR the per-driver flags
module lfs_status_regs (
  // Clock and reset
  input  wire logic          core_clk_in,
  input  wire logic          rst_in,
  // Register access from the serial front end
  input  wire logic [4:0]    reg_addr_in,
  input  wire logic          reg_wr_in,
  input  wire logic          reg_rd_in,
  input  wire logic [12:0]   reg_wdata_in,
  output logic      [12:0]   reg_rdata_out,
  output logic               reg_rvalid_out,
  // Fault detector levels, asynchronous
  input  wire logic [11:0]   any_open_summary_det_in,
  input  wire logic [11:0]   open_trace_det_in,
  input  wire logic [11:0]   short_led_det_in,
  // Normal dimming switch request, one means closed
  input  wire logic [11:0]   normal_sw_closed_in,
  // Group phase write
  input  wire logic          group_phase_write_in,
  input  wire logic [3:0]    phase_group_select_in,
  input  wire logic [3:0]    phase_value_in,
  // Group transition write
  input  wire logic          transition_write_in,
  input  wire logic [3:0]    transition_group_select_in,
  input  wire logic [3:0]    transition_dimming_setting_in,
  // Group duty writes
  input  wire logic          first_group_duty_wr_in,
  input  wire logic          second_group_duty_wr_in,
  input  wire logic [11:0]   group_duty_in,
  // Switch drive and driver settings
  output logic      [11:0]   switch_closed_out,
  output logic      [47:0]   drv_phase_out,
  output logic      [47:0]   drv_transition_out,
  output logic      [143:0]  drv_eff_duty_out,
  // Summaries and alert
  output logic               any_open_summary_out,
  output logic               any_trace_summary_out,
  output logic               any_short_summary_out,
  output logic               fault_alert_pin_n_out
);

  // ********************************
  // Declarations
  // ********************************
  logic [11:0] force_closed_bits_r;
  logic [11:0] first_group_mask_r;
  logic [11:0] second_group_mask_r;
  logic [11:0] switch_closed_r;
  logic [11:0] switch_closed_nxt;
  logic [12:0] rdata_r;
  logic [12:0] rdata_nxt;
  logic        rvalid_r;
  logic        alert_n_r;
  logic [11:0] any_open_summary_flags;
  logic [11:0] open_trace_flags;
  logic [11:0] shorted_led_flags;
  logic        any_open;
  logic        any_trace;
  logic        any_short;
  wire  [11:0] switch_open;
  wire         sel_any_open_summary;
  wire         sel_open_trace;
  wire         sel_force;
  wire         sel_short_led;
  wire         sel_group_a;
  wire         sel_group_b;
  wire         clr_any_open_summary;
  wire         clr_open_trace;
  wire         clr_short_led;
  wire  [11:0] wr_field;

  // ********************************
  // Address decode
  // ********************************

  // Register selects
  assign sel_any_open_summary   = (reg_addr_in == lfs_pkg::OFS_ANY_OPEN_SUMMARY_STATUS);
  assign sel_open_trace = (reg_addr_in == lfs_pkg::OFS_OPEN_TRACE_STATUS);
  assign sel_force      = (reg_addr_in == lfs_pkg::OFS_SWITCH_FORCE_CLOSED);
  assign sel_short_led  = (reg_addr_in == lfs_pkg::OFS_SHORT_LED_STATUS);
  assign sel_group_a    = (reg_addr_in == lfs_pkg::OFS_GROUP_A_MEMBERS);
  assign sel_group_b    = (reg_addr_in == lfs_pkg::OFS_GROUP_B_MEMBERS);

  // Read of a status register clears all its flags except those set in the same cycle
  assign clr_any_open_summary   = reg_rd_in & sel_any_open_summary;
  assign clr_open_trace = reg_rd_in & sel_open_trace;
  assign clr_short_led  = reg_rd_in & sel_short_led;

  // Driver field of write data; bit 12 is unused
  assign wr_field = reg_wdata_in[lfs_pkg::FLD_DRV_MSB:lfs_pkg::FLD_DRV_LSB];

  // ********************************
  // Writable registers
  // ********************************

  // Override and group masks; writes to status offsets are ignored
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      force_closed_bits_r <= lfs_pkg::RST_FORCE;
      first_group_mask_r  <= lfs_pkg::RST_GROUP;
      second_group_mask_r <= lfs_pkg::RST_GROUP;
    end else begin
      if (reg_wr_in && sel_force) force_closed_bits_r <= wr_field;
      if (reg_wr_in && sel_group_a) first_group_mask_r <= wr_field;
      if (reg_wr_in && sel_group_b) second_group_mask_r <= wr_field;
    end
  end

  // ********************************
  // Switch control
  // ********************************

  // Override forces closed, otherwise the normal request passes through
  assign switch_closed_nxt = force_closed_bits_r | normal_sw_closed_in;
  assign switch_open       = ~switch_closed_r;

  // Registered switch drive
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      switch_closed_r <= '0;
    end else begin
      switch_closed_r <= switch_closed_nxt;
    end
  end

  assign switch_closed_out = switch_closed_r;

  // ********************************
  // Fault flag banks
  // ********************************

  // Any_open_summary flags
  lfs_flag_bank #(
    .N (lfs_pkg::DRIVERS)
  ) u_any_open_summary (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .det_in         (any_open_summary_det_in),
    .switch_open_in (switch_open),
    .clear_in       (clr_any_open_summary),
    .flags_out      (any_open_summary_flags),
    .any_out        (any_open)
  );

  // Open-trace flags
  lfs_flag_bank #(
    .N (lfs_pkg::DRIVERS)
  ) u_open_trace (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .det_in         (open_trace_det_in),
    .switch_open_in (switch_open),
    .clear_in       (clr_open_trace),
    .flags_out      (open_trace_flags),
    .any_out        (any_trace)
  );

  // Shorted-LED flags
  lfs_flag_bank #(
    .N (lfs_pkg::DRIVERS)
  ) u_short_led (
    .core_clk_in    (core_clk_in),
    .rst_in         (rst_in),
    .det_in         (short_led_det_in),
    .switch_open_in (switch_open),
    .clear_in       (clr_short_led),
    .flags_out      (shorted_led_flags),
    .any_out        (any_short)
  );

  // Summary bits
  assign any_open_summary_out  = any_open;
  assign any_trace_summary_out = any_trace;
  assign any_short_summary_out = any_short;

  // Alert pin low one cycle after any fault flag is held, registered
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      alert_n_r <= 1'b1;
    end else begin
      alert_n_r <= ~(any_open | any_trace | any_short);
    end
  end

  assign fault_alert_pin_n_out = alert_n_r;

  // ********************************
  // Read path
  // ********************************

  // Read mux; unmapped offsets read as zero, bit 12 reads zero
  always_comb begin
    rdata_nxt = '0;
    case (1'b1)
      sel_any_open_summary:   rdata_nxt = {1'b0, any_open_summary_flags};
      sel_open_trace: rdata_nxt = {1'b0, open_trace_flags};
      sel_force:      rdata_nxt = {1'b0, force_closed_bits_r};
      sel_short_led:  rdata_nxt = {1'b0, shorted_led_flags};
      sel_group_a:    rdata_nxt = {1'b0, first_group_mask_r};
      sel_group_b:    rdata_nxt = {1'b0, second_group_mask_r};
      default:        rdata_nxt = '0;
    endcase
  end

  // Read data captured on the read strobe, held until the next read
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd_in;
      if (reg_rd_in) rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out  = rdata_r;
  assign reg_rvalid_out = rvalid_r;

  // ********************************
  // Per-driver group lanes
  // ********************************

  // One lane per driver, fed by its membership and override bits
  for (genvar i = 0; i < lfs_pkg::DRIVERS; i++) begin : g_lane
    lfs_group_lane u_lane (
      .core_clk_in  (core_clk_in),
      .rst_in       (rst_in),
      .member_a_in  (first_group_mask_r[i]),
      .member_b_in  (second_group_mask_r[i]),
      .force_in     (force_closed_bits_r[i]),
      .phase_wr_in  (group_phase_write_in),
      .phase_sel_in (phase_group_select_in),
      .phase_val_in (phase_value_in),
      .transition_dimming_setting_wr_in   (transition_write_in),
      .transition_dimming_setting_sel_in  (transition_group_select_in),
      .transition_dimming_setting_val_in  (transition_dimming_setting_in),
      .duty_a_wr_in (first_group_duty_wr_in),
      .duty_b_wr_in (second_group_duty_wr_in),
      .duty_val_in  (group_duty_in),
      .phase_out    (drv_phase_out[4*i +: 4]),
      .transition_dimming_setting_out     (drv_transition_out[4*i +: 4]),
      .eff_duty_out (drv_eff_duty_out[12*i +: 12])
    );
  end

endmodule
